// >>> rtl/cfms_top.sv
// Purpose: Per-filter acceptance mask source selection with AXI4-Lite registers
// Assumes: One clock, synchronous active-low reset, bus master on the same clock
// Notes: Mask and filter identifiers come from neighbouring logic as plain ports
`timescale 1ns/1ps
`default_nettype none
module cfms_top
  import cfms_pkg::*;
#(
  parameter int unsigned NFILT = cfms_pkg::NUM_FILTERS,
  parameter int unsigned IDW = cfms_pkg::ID_WIDTH
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [cfms_pkg::ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [cfms_pkg::ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [IDW-1:0] mask0_id,
  input wire logic [IDW-1:0] mask1_id,
  input wire logic [IDW-1:0] mask2_id,
  input wire logic [NFILT*IDW-1:0] filter_id,
  input wire logic [IDW-1:0] rx_id,
  output logic [NFILT*2-1:0] filter_mask_index,
  output logic [NFILT-1:0] filter_hit
);
  import cfms_pkg::*;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [ADDR_WIDTH-1:0] awaddr;
    logic aw_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic w_held;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [15:0] filter_mask_source_low;
    logic [15:0] filter_mask_source_high;
    logic [NFILT*2-1:0] index;
    logic [NFILT-1:0] hit;
  } cfms_state_t;

  cfms_state_t st;
  cfms_state_t next_st;
  logic [NFILT-1:0] raw_hit;
  logic [IDW-1:0] sel_mask [NFILT];

  //////////////////////////////////////////////////////////////////////////////
  // Byte-lane merge used by the write path of both registers
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = d[7:0];
    end
    if (be[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  // One decode serves every filter, so all fields share the encoding
  function automatic logic [IDW-1:0] pick_mask(input logic [1:0] src);
    logic [IDW-1:0] m;
    m = '0;
    unique case (src)
      SOURCE_MASK0: m = mask0_id;
      SOURCE_MASK1: m = mask1_id;
      SOURCE_MASK2: m = mask2_id;
      SOURCE_NONE: m = '0; // No mask: every bit don't-care
    endcase
    return m;
  endfunction

  // Address decode shared by the write and the read path; bit 0 low, bit 1 high
  function automatic logic [1:0] reg_sel(input logic [ADDR_WIDTH-1:0] addr);
    logic [1:0] s;
    s = 2'h0;
    if (addr == OFFSET_LOW) begin
      s = 2'h1;
    end else if (addr == OFFSET_HIGH) begin
      s = 2'h2;
    end
    return s;
  endfunction

  // Filters 0-7 sit in the low register, 8-15 in the high one
  function automatic logic [1:0] source_of(input int unsigned n, input logic [15:0] lo,
                                           input logic [15:0] hi);
    logic [1:0] f;
    f = 2'h0;
    if (n < FILTERS_PER_REG) begin
      f = lo[FIELD_WIDTH*n +: FIELD_WIDTH];
    end else begin
      f = hi[FIELD_WIDTH*(n-FILTERS_PER_REG) +: FIELD_WIDTH];
    end
    return f;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Every filter's code, filter n at bits 2n+1:2n, as the index port shows it
  logic [NFILT*2-1:0] sources;
  logic [1:0] wr_sel;
  logic [1:0] rd_sel;
  assign wr_sel = reg_sel(st.awaddr);
  assign rd_sel = reg_sel(s_axi_araddr);

  for (genvar n = 0; n < NFILT; n++) begin : g_filt
    logic [1:0] src;
    assign src = source_of(n, st.filter_mask_source_low, st.filter_mask_source_high);
    assign sources[2*n +: 2] = src;
    assign sel_mask[n] = pick_mask(src);
    cfms_match #(.WIDTH(IDW)) u_match (
      .rx_id(rx_id),
      .filter_id(filter_id[n*IDW +: IDW]),
      .mask(sel_mask[n]),
      .hit(raw_hit[n])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    next_st.index = sources[NFILT*2-1:0];
    next_st.hit = raw_hit;
    // Address and data may arrive in either order; each is held until both exist
    if (s_axi_awvalid && st.awready) begin
      next_st.awaddr = s_axi_awaddr;
      next_st.aw_held = 1'b1;
      next_st.awready = 1'b0;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
      next_st.w_held = 1'b1;
      next_st.wready = 1'b0;
    end
    if (st.aw_held && st.w_held && !st.bvalid) begin
      next_st.bvalid = 1'b1;
      next_st.bresp = AXI_OKAY;
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      // Full 16-bit read/write access
      if (wr_sel[0]) begin
        next_st.filter_mask_source_low = merge16(st.filter_mask_source_low, st.wdata, st.wstrb);
      end else if (wr_sel[1]) begin
        next_st.filter_mask_source_high = merge16(st.filter_mask_source_high, st.wdata,
                                                  st.wstrb);
      end else begin
        next_st.bresp = AXI_SLVERR;
      end
    end
    // Ready reopens only after the response is accepted, keeping one write in flight
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
      next_st.awready = 1'b1;
      next_st.wready = 1'b1;
    end
    if (s_axi_arvalid && st.arready) begin
      next_st.arready = 1'b0;
      next_st.rvalid = 1'b1;
      next_st.rresp = AXI_OKAY;
      next_st.rdata = 32'h0000_0000;
      if (rd_sel[0]) begin
        next_st.rdata[15:0] = st.filter_mask_source_low;
      end else if (rd_sel[1]) begin
        next_st.rdata[15:0] = st.filter_mask_source_high;
      end else begin
        next_st.rresp = AXI_SLVERR;
      end
    end
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
      next_st.arready = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st <= '0;
      st.awready <= 1'b1;
      st.wready <= 1'b1;
      st.arready <= 1'b1;
      st.filter_mask_source_low <= RESET_SOURCE;
      st.filter_mask_source_high <= RESET_SOURCE;
    end else begin
      st <= next_st;
    end
  end

  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign filter_mask_index = st.index;
  assign filter_hit = st.hit;
endmodule
`default_nettype wire

// >>> rtl/cfms_pkg.sv
// Purpose: Constants for the filter mask source selection block
// Assumes: AXI4-Lite register access, 32-bit data, 16-bit registers in low bits
// Notes: Offsets are chosen here; every register takes one aligned word
// Contract
// - Each filter has a 2-bit mask source field; filter 7 at low bits 15-14; 11 = no mask.
// - Field value 10 selects acceptance mask set 2.
// - Field value 01 selects acceptance mask set 1.
// - Field value 00 selects acceptance mask set 0.
// - All sixteen filter fields decode with the same four-value encoding.
// - Filters 0-7 sit in the low register, filter n at bits 2n+1:2n.
// - Mask bit 1 includes the identifier bit; mask bit 0 makes it don't-care.
// - Each compared identifier bit must equal the filter's programmed bit.
package cfms_pkg;
  localparam int unsigned NUM_FILTERS = 16;
  localparam int unsigned ID_WIDTH = 29;
  localparam int unsigned ADDR_WIDTH = 4;
  localparam logic [3:0] OFFSET_LOW = 4'h0;
  localparam logic [3:0] OFFSET_HIGH = 4'h4;
  localparam logic [15:0] RESET_SOURCE = 16'h0000;
  localparam int unsigned FIELD_WIDTH = 2;
  localparam int unsigned FILTERS_PER_REG = 8;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  localparam logic [1:0] SOURCE_MASK0 = 2'h0;
  localparam logic [1:0] SOURCE_MASK1 = 2'h1;
  localparam logic [1:0] SOURCE_MASK2 = 2'h2;
  localparam logic [1:0] SOURCE_NONE = 2'h3;
endpackage

// >>> rtl/cfms_match.sv
// Purpose: Masked identifier compare for one filter
// Assumes: Inputs are registered on the same clock
// Notes: Purely combinational; the top registers the result
`timescale 1ns/1ps
`default_nettype none
module cfms_match #(
  parameter int unsigned WIDTH = 29
) (
  input wire logic [WIDTH-1:0] rx_id,
  input wire logic [WIDTH-1:0] filter_id,
  input wire logic [WIDTH-1:0] mask,
  output logic hit
);
  // Set mask bits are compared, clear ones ignored
  assign hit = ((rx_id ^ filter_id) & mask) == '0;
endmodule
`default_nettype wire

// >>> tb/cfms_checker.sv
// Purpose: Concurrent checks on the mask source selection block
// Assumes: Index and hit register one cycle after their causes
// Notes: Filters 0, 7 and 15 stand in for the shared decode
`timescale 1ns/1ps
`default_nettype none
module cfms_checker #(
  parameter int unsigned NFILT = 16,
  parameter int unsigned IDW = 29
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic [IDW-1:0] mask0_id,
  input wire logic [IDW-1:0] mask1_id,
  input wire logic [IDW-1:0] mask2_id,
  input wire logic [NFILT*IDW-1:0] filter_id,
  input wire logic [IDW-1:0] rx_id,
  input wire logic [NFILT*2-1:0] filter_mask_index,
  input wire logic [NFILT-1:0] filter_hit
);
  logic [IDW-1:0] rq, m0q, m1q, m2q;
  logic [NFILT*IDW-1:0] fq;
  // Hit reflects the inputs of the previous cycle
  always_ff @(posedge mclk) begin
    {rq, m0q, m1q, m2q, fq} <= {rx_id, mask0_id, mask1_id, mask2_id, filter_id};
  end
  ////////////////////////////////////////////////////////////
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  r_answer_a: assert property (ar_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("read data upper bits set");
  b_clear_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  index_write_a: assert property ($changed(filter_mask_index) |->
    $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2)) else $error("index moved without write");
  no_mask_a: assert property (filter_mask_index[1:0] == 2'h3 |-> filter_hit[0])
    else $error("unmasked filter missed");
  mask0_hit_a: assert property ($past(rst_b) && filter_mask_index[1:0] == 2'h0 |->
    filter_hit[0] == (((rq ^ fq[IDW-1:0]) & m0q) == '0)) else $error("mask set 0 hit wrong");
  mask1_hit_a: assert property ($past(rst_b) && filter_mask_index[15:14] == 2'h1 |->
    filter_hit[7] == (((rq ^ fq[7*IDW+:IDW]) & m1q) == '0)) else $error("mask set 1 hit wrong");
  mask2_hit_a: assert property ($past(rst_b) && filter_mask_index[31:30] == 2'h2 |->
    filter_hit[15] == (((rq ^ fq[15*IDW+:IDW]) & m2q) == '0)) else $error("mask set 2 hit wrong");
endmodule
bind cfms_top cfms_checker #(.NFILT(NFILT), .IDW(IDW)) u_chk (.mclk(mclk), .rst_b(rst_b),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .mask0_id(mask0_id), .mask1_id(mask1_id), .mask2_id(mask2_id), .filter_id(filter_id),
  .rx_id(rx_id), .filter_mask_index(filter_mask_index), .filter_hit(filter_hit));
`default_nettype wire

// >>> tb/tb_top.sv
// Purpose: Self-checking bench for the mask source selection block
// Assumes: Bus outputs sampled at rising edges
// Notes: Random fields and identifiers from a fixed xorshift seed
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import cfms_pkg::*;
  logic mclk = '0, rst_b = '0, awv = '0, wv = '0, bre = '0, arv = '0, rre = '0;
  logic awr, wrd, bv, arr, rv;
  logic [1:0] br, rr, r;
  logic [3:0] aa = '0, ws = 4'hF;
  logic [31:0] wd = '0, rd, idx, q, seed = 32'h0000_3373;
  logic [28:0] rx = '0, m0 = '0, m1 = '0, m2 = '0, t;
  logic [463:0] fid = '0;
  logic [15:0] hit, lo, hi;
  int mismatches = 0, compares = 0;
  always #12.5 mclk = ~mclk;
  cfms_top u_dut (.mclk(mclk), .rst_b(rst_b), .s_axi_awaddr(aa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_araddr(aa), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre), .mask0_id(m0), .mask1_id(m1),
    .mask2_id(m2), .filter_id(fid), .rx_id(rx), .filter_mask_index(idx), .filter_hit(hit));
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] model();
    logic [15:0] h;
    logic [1:0] c;
    logic [28:0] m;
    for (int n = 0; n < 16; n++) begin
      c = n < 8 ? lo[2*n+:2] : hi[2*n-16+:2];
      m = c == 2'h0 ? m0 : c == 2'h1 ? m1 : c == 2'h2 ? m2 : '0;
      h[n] = ((rx ^ fid[n*29+:29]) & m) == '0;
    end
    return h;
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Response ready is raised with the request so no answer is missed
  task automatic xfer(input bit w, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk);
    aa <= a;
    wd <= d;
    {awv, wv, bre} <= {3{w}};
    {arv, rre} <= {2{!w}};
    for (i = 0; i < 40; i++) begin
      @(posedge mclk);
      if (awr) awv <= '0;
      if (wrd) wv <= '0;
      if (arr) arv <= '0;
      if (bv || rv) break;
    end
    q = rd;
    r = w ? br : rr;
    {bre, rre} <= '0;
    if (i == 40) begin
      mismatches++;
      test_done();
    end
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    rst_b <= '1;
    xfer(1, 4'h8, 32'hFFFF);
    chk("unmapped bresp", {30'h0, r}, {30'h0, AXI_SLVERR});
    xfer(0, 4'hC, '0);
    chk("unmapped rresp", {30'h0, r}, {30'h0, AXI_SLVERR});
    chk("unmapped rdata", q, 32'h0);
    xfer(0, OFFSET_LOW, '0);
    chk("low reset", q, 32'h0);
    xfer(0, OFFSET_HIGH, '0);
    chk("high reset", q, 32'h0);
    chk("index reset", idx, 32'h0);
    repeat (12) begin
      lo = 16'(xs());
      hi = 16'(xs());
      xfer(1, OFFSET_LOW, {16'h0, lo});
      xfer(1, OFFSET_HIGH, {16'h0, hi});
      chk("write bresp", {30'h0, r}, {30'h0, AXI_OKAY});
      // Upper byte lane only: the lower byte must keep its value
      ws <= 4'h2;
      xfer(1, OFFSET_LOW, {16'h0, ~lo});
      ws <= 4'hF;
      lo[15:8] = ~lo[15:8];
      xfer(0, OFFSET_LOW, '0);
      chk("low readback", q, {16'h0, lo});
      chk("read rresp", {30'h0, r}, {30'h0, AXI_OKAY});
      xfer(0, OFFSET_HIGH, '0);
      chk("high readback", q, {16'h0, hi});
      chk("index", idx, {hi, lo});
      t = 29'(xs());
      rx <= t;
      {m0, m1, m2} <= {29'(xs()), 29'(xs()), 29'(xs())};
      for (int n = 0; n < 16; n++) fid[n*29+:29] <= t ^ 29'(xs() & xs() & xs());
      repeat (2) @(posedge mclk);
      chk("hits", {16'h0, hit}, {16'h0, model()});
    end
    // Reset in mid-run must clear both registers and the index again
    rst_b <= '0;
    repeat (2) @(posedge mclk);
    rst_b <= '1;
    xfer(0, OFFSET_HIGH, '0);
    chk("high after reset", q, 32'h0);
    chk("index after reset", idx, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
